// ---- secure_region_consts.vh ----
// Purpose: constants for the secure region host controller
// Assumes: 16-bit word-mode parallel flash bus
// Notes:   addresses are word addresses relative to the device base
`ifndef SECURE_REGION_CONSTS_VH
`define SECURE_REGION_CONSTS_VH

`define ADDR_W            24
`define DATA_W            16
`define ADDR_UNLOCK1      24'h000555
`define ADDR_UNLOCK2      24'h0002AA
`define DATA_UNLOCK1      16'h00AA
`define DATA_UNLOCK2      16'h0055
`define DATA_ENTER        16'h0088
`define DATA_PROG_SETUP   16'h00A0
`define DATA_EXIT3        16'h0090
`define DATA_EXIT4        16'h0000
`define DATA_ID_ENTER     16'h0090
`define DATA_ID_EXIT      16'h00F0
`define ADDR_ID_LOCK      24'h000003
`define LOCK_BIT_POS      7
`define REGION_WORDS      128
`define SERIAL_WORDS      8
`define SECTOR0_LAST      24'h00FFFF
`define POLL_BIT_POS      7
`define CLK_PERIOD_NS     8
`define T_WRITE_NS        70
`define T_READ_NS         110
`define T_RESET_NS        500
`define T_WRITE_CYC       (((`T_WRITE_NS)+(`CLK_PERIOD_NS)-1)/(`CLK_PERIOD_NS))
`define T_READ_CYC        (((`T_READ_NS)+(`CLK_PERIOD_NS)-1)/(`CLK_PERIOD_NS))
`define T_RESET_CYC       (((`T_RESET_NS)+(`CLK_PERIOD_NS)-1)/(`CLK_PERIOD_NS))
`define CMD_ENTER         3'h1
`define CMD_PROGRAM       3'h2
`define CMD_EXIT          3'h3
`define CMD_READ          3'h4
`define CMD_LOCKBIT       3'h5
`define CMD_RESET         3'h6

`endif

// ---- bus_cycle.v ----
// Purpose: one timed write or read cycle on the flash parallel bus
// Assumes: core_clk at 125 MHz, flash inputs synchronous to it
// Notes:   data read is captured at the end of the access time
`timescale 1ns/1ns
`default_nettype none
`include "secure_region_consts.vh"
module bus_cycle
(
  input  wire                 core_clk,
  input  wire                 rstn,
  input  wire                 start,
  input  wire                 isWrite,
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [`DATA_W-1:0]   wdata,
  input  wire [`DATA_W-1:0]   dqIn,
  output reg                  done,
  output reg  [`DATA_W-1:0]   rdata,
  output reg  [`ADDR_W-1:0]   flashAddr,
  output reg  [`DATA_W-1:0]   dqOut,
  output reg                  dqOe,
  output reg                  ceN,
  output reg                  oeN,
  output reg                  weN
);
  localparam integer WR_INT = `T_WRITE_CYC;
  localparam integer RD_INT = `T_READ_CYC;
  localparam [7:0]   WR_CYC = WR_INT[7:0];
  localparam [7:0]   RD_CYC = RD_INT[7:0];
  reg [7:0] cnt_ff;
  reg       busy_ff;

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_ff    <= 8'h00;
      busy_ff   <= 1'b0;
      done      <= 1'b0;
      rdata     <= 16'h0000;
      flashAddr <= 24'h000000;
      dqOut     <= 16'h0000;
      dqOe      <= 1'b0;
      ceN       <= 1'b1;
      oeN       <= 1'b1;
      weN       <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      if (!busy_ff && start)
      begin
        busy_ff   <= 1'b1;
        flashAddr <= addr;
        dqOut     <= wdata;
        dqOe      <= isWrite;
        ceN       <= 1'b0;
        weN       <= ~isWrite;
        oeN       <= isWrite;
        cnt_ff    <= isWrite ? WR_CYC : RD_CYC;
      end
      else if (busy_ff)
      begin
        if (cnt_ff > 8'h01)
          cnt_ff <= cnt_ff - 8'h01;
        else
        begin
          // release strobes; write latches on weN rising
          busy_ff <= 1'b0;
          done    <= 1'b1;
          if (!oeN)
            rdata <= dqIn;
          ceN  <= 1'b1;
          oeN  <= 1'b1;
          weN  <= 1'b1;
          dqOe <= 1'b0;
        end
      end
    end
  end
endmodule // bus_cycle
`default_nettype wire

// ---- secure_region_host.v ----
// Purpose: host controller issuing secure region command sequences
// Assumes: word-mode flash, user orders on a plain request port
// Notes:   one order at a time; busy until the order completes
// Operation
// - After reading the lock bit at 03h, the host writes F0h to leave ID mode.
// - Entry is AAh to 555h, 55h to 2AAh, then 88h to 555h.
// - Programming is AAh, 55h, A0h, then the data word, then polling.
// - Exit is AAh to 555h, 55h to 2AAh, 90h to 555h, then 00h anywhere.
`timescale 1ns/1ns
`default_nettype none
`include "secure_region_consts.vh"
module secure_region_host
(
  input  wire                 core_clk,
  input  wire                 rstn,
  input  wire                 cmdValid,
  input  wire [2:0]           cmdCode,
  input  wire [`ADDR_W-1:0]   cmdAddr,
  input  wire [`DATA_W-1:0]   cmdData,
  input  wire [`DATA_W-1:0]   dqIn,
  output reg                  cmdBusy_ff,
  output reg                  cmdDone_ff,
  output reg                  cmdError_ff,
  output reg  [`DATA_W-1:0]   rspData_ff,
  output reg                  regionMode_ff,
  output reg                  lockIndicator_ff,
  output wire [`ADDR_W-1:0]   flashAddr,
  output wire [`DATA_W-1:0]   dqOut,
  output wire                 dqOe,
  output wire                 ceN,
  output wire                 oeN,
  output wire                 weN,
  output reg                  resetN_ff
);
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_SEQ   = 4'h1;
  localparam [3:0] ST_WAIT  = 4'h2;
  localparam [3:0] ST_POLL  = 4'h3;
  localparam [3:0] ST_PWAIT = 4'h4;
  localparam [3:0] ST_RST   = 4'h5;
  localparam [3:0] ST_FIN   = 4'h6;
  localparam integer RST_INT = `T_RESET_CYC;
  localparam [9:0] RST_CYC  = RST_INT[9:0];

  reg  [3:0]         state_ff;
  reg  [2:0]         code_ff;
  reg  [2:0]         step_ff;
  reg  [`ADDR_W-1:0] addr_ff;
  reg  [`DATA_W-1:0] data_ff;
  reg  [9:0]         rstCnt_ff;
  reg                start_ff;
  reg                isWr_ff;
  reg  [`ADDR_W-1:0] cycAddr_ff;
  reg  [`DATA_W-1:0] cycData_ff;
  wire               cycDone;
  wire [`DATA_W-1:0] cycRdata;
  reg  [2:0]         nSteps;
  reg  [`ADDR_W-1:0] stepAddr;
  reg  [`DATA_W-1:0] stepData;
  reg                stepWr;
  reg                badOrder;

  bus_cycle u_cycle
  (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .start     (start_ff),
    .isWrite   (isWr_ff),
    .addr      (cycAddr_ff),
    .wdata     (cycData_ff),
    .dqIn      (dqIn),
    .done      (cycDone),
    .rdata     (cycRdata),
    .flashAddr (flashAddr),
    .dqOut     (dqOut),
    .dqOe      (dqOe),
    .ceN       (ceN),
    .oeN       (oeN),
    .weN       (weN)
  );

  // sequence tables: cycle address, data and direction per step
  always @*
  begin
    nSteps   = 3'd1;
    stepAddr = addr_ff;
    stepData = data_ff;
    stepWr   = 1'b1;
    if (step_ff == 3'd0)
    begin
      stepAddr = `ADDR_UNLOCK1;
      stepData = `DATA_UNLOCK1;
    end
    else if (step_ff == 3'd1)
    begin
      stepAddr = `ADDR_UNLOCK2;
      stepData = `DATA_UNLOCK2;
    end
    case (code_ff)
      `CMD_ENTER:
      begin
        nSteps = 3'd3;
        if (step_ff == 3'd2)
        begin
          stepAddr = `ADDR_UNLOCK1;
          stepData = `DATA_ENTER;
        end
      end
      `CMD_PROGRAM:
      begin
        nSteps = 3'd4;
        if (step_ff == 3'd2)
        begin
          stepAddr = `ADDR_UNLOCK1;
          stepData = `DATA_PROG_SETUP;
        end
      end
      `CMD_EXIT:
      begin
        nSteps = 3'd4;
        if (step_ff == 3'd2)
        begin
          stepAddr = `ADDR_UNLOCK1;
          stepData = `DATA_EXIT3;
        end
        else if (step_ff == 3'd3)
          stepData = `DATA_EXIT4;
      end
      `CMD_LOCKBIT:
      begin
        nSteps = 3'd5;
        if (step_ff == 3'd2)
        begin
          stepAddr = `ADDR_UNLOCK1;
          stepData = `DATA_ID_ENTER;
        end
        else if (step_ff == 3'd3)
        begin
          stepAddr = `ADDR_ID_LOCK;
          stepWr   = 1'b0;
        end
        else if (step_ff == 3'd4)
          stepData = `DATA_ID_EXIT;
      end
      `CMD_READ:
      begin
        // a plain read goes to the order address, not an unlock address
        stepAddr = addr_ff;
        stepData = data_ff;
        stepWr   = 1'b0;
      end
      default:
        nSteps = 3'd1;
    endcase
  end

  // program only inside region mode and within the 128-word region
  always @*
  begin
    badOrder = 1'b0;
    if (cmdCode == `CMD_PROGRAM)
      badOrder = !regionMode_ff || (cmdAddr >= `REGION_WORDS);
    else if (cmdCode == `CMD_ENTER)
      badOrder = regionMode_ff;
    else if (cmdCode == `CMD_EXIT || cmdCode == `CMD_LOCKBIT)
      badOrder = (cmdCode == `CMD_EXIT) ? !regionMode_ff : regionMode_ff;
    else if (cmdCode == `CMD_READ)
      badOrder = regionMode_ff && (cmdAddr <= `SECTOR0_LAST)
                 && (cmdAddr >= `REGION_WORDS);
    else if (cmdCode != `CMD_RESET)
      badOrder = 1'b1;
  end

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff         <= ST_IDLE;
      code_ff          <= 3'h0;
      step_ff          <= 3'h0;
      addr_ff          <= 24'h000000;
      data_ff          <= 16'h0000;
      rstCnt_ff        <= 10'h000;
      start_ff         <= 1'b0;
      isWr_ff          <= 1'b0;
      cycAddr_ff       <= 24'h000000;
      cycData_ff       <= 16'h0000;
      cmdBusy_ff       <= 1'b0;
      cmdDone_ff       <= 1'b0;
      cmdError_ff      <= 1'b0;
      rspData_ff       <= 16'h0000;
      regionMode_ff    <= 1'b0;
      lockIndicator_ff <= 1'b0;
      resetN_ff        <= 1'b0;
    end
    else
    begin
      start_ff   <= 1'b0;
      cmdDone_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          resetN_ff <= 1'b1;
          if (cmdValid)
          begin
            code_ff     <= cmdCode;
            addr_ff     <= cmdAddr;
            data_ff     <= cmdData;
            step_ff     <= 3'h0;
            cmdError_ff <= 1'b0;
            if (badOrder)
            begin
              cmdError_ff <= 1'b1;
              cmdDone_ff  <= 1'b1;
            end
            else if (cmdCode == `CMD_RESET)
            begin
              cmdBusy_ff <= 1'b1;
              resetN_ff  <= 1'b0;
              rstCnt_ff  <= RST_CYC;
              state_ff   <= ST_RST;
            end
            else
            begin
              cmdBusy_ff <= 1'b1;
              state_ff   <= ST_SEQ;
            end
          end
        end
        ST_SEQ:
        begin
          cycAddr_ff <= stepAddr;
          cycData_ff <= stepData;
          isWr_ff    <= stepWr;
          start_ff   <= 1'b1;
          state_ff   <= ST_WAIT;
        end
        ST_WAIT:
          if (cycDone)
          begin
            if (!isWr_ff)
              rspData_ff <= cycRdata;
            if (code_ff == `CMD_LOCKBIT && step_ff == 3'd3)
              lockIndicator_ff <= cycRdata[`LOCK_BIT_POS];
            if (step_ff == nSteps - 3'd1)
              state_ff <= (code_ff == `CMD_PROGRAM) ? ST_POLL : ST_FIN;
            else
            begin
              step_ff  <= step_ff + 3'd1;
              state_ff <= ST_SEQ;
            end
          end
        ST_POLL:
        begin
          cycAddr_ff <= addr_ff;
          isWr_ff    <= 1'b0;
          start_ff   <= 1'b1;
          state_ff   <= ST_PWAIT;
        end
        ST_PWAIT:
          if (cycDone)
          begin
            // toggle-free check: bit seven matches the data when finished
            if (cycRdata[`POLL_BIT_POS] == data_ff[`POLL_BIT_POS])
            begin
              rspData_ff <= cycRdata;
              state_ff   <= ST_FIN;
            end
            else
              state_ff <= ST_POLL;
          end
        ST_RST:
          if (rstCnt_ff > 10'h001)
            rstCnt_ff <= rstCnt_ff - 10'h001;
          else
          begin
            resetN_ff     <= 1'b1;
            regionMode_ff <= 1'b0;
            state_ff      <= ST_FIN;
          end
        ST_FIN:
        begin
          if (code_ff == `CMD_ENTER)
            regionMode_ff <= 1'b1;
          else if (code_ff == `CMD_EXIT)
            regionMode_ff <= 1'b0;
          cmdBusy_ff <= 1'b0;
          cmdDone_ff <= 1'b1;
          state_ff   <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule // secure_region_host
`default_nettype wire

// ---- secure_region_host_monitor.sv ----
// Purpose: port checks on the secure region host
// Assumes: one clock domain, rstn active low
// Notes:   bound onto every host instance
`timescale 1ns/1ns
`default_nettype none
`include "secure_region_consts.vh"
module secure_region_host_monitor
(
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        cmdDone_ff,
  input wire logic        cmdError_ff,
  input wire logic        regionMode_ff,
  input wire logic        lockIndicator_ff,
  input wire logic [23:0] flashAddr,
  input wire logic [15:0] dqOut,
  input wire logic        dqOe,
  input wire logic        ceN,
  input wire logic        oeN,
  input wire logic        weN,
  input wire logic        resetN_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_enter;
    !weN && dqOut == `DATA_ENTER |-> flashAddr == `ADDR_UNLOCK1;
  endproperty
  a_enter: assert property (p_enter)
    else $error("entry code at wrong address");
  property p_unlock;
    !weN && dqOut == `DATA_UNLOCK2 |-> flashAddr == `ADDR_UNLOCK2;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("second unlock at wrong address");
  property p_setup;
    !weN && dqOut == `DATA_PROG_SETUP |-> flashAddr == `ADDR_UNLOCK1;
  endproperty
  a_setup: assert property (p_setup)
    else $error("program setup at wrong address");
  property p_wr_len;
    $fell(weN) |-> ##1 (!weN)[*8] ##1 weN;
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("write strobe length wrong");
  property p_rd_len;
    $fell(oeN) |-> ##1 (!oeN)[*8] ##5 !oeN ##1 oeN;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read strobe length wrong");
  property p_wr_bus;
    !weN |-> !ceN && oeN && dqOe;
  endproperty
  a_wr_bus: assert property (p_wr_bus)
    else $error("write without select or drive");
  property p_lock;
    $changed(lockIndicator_ff) |-> !regionMode_ff;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock bit taken in region mode");
  property p_reset;
    $fell(resetN_ff) |-> ##[1:70] !regionMode_ff;
  endproperty
  a_reset: assert property (p_reset)
    else $error("mode kept after device reset");
  property p_refuse;
    $rose(cmdError_ff) |-> cmdDone_ff && weN && oeN;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refusal without done or with bus cycle");
  property p_done;
    cmdDone_ff |=> !cmdDone_ff;
  endproperty
  a_done: assert property (p_done)
    else $error("done longer than one cycle");
endmodule // secure_region_host_monitor
bind secure_region_host secure_region_host_monitor u_secure_region_host_monitor
(
  .core_clk, .rstn, .cmdDone_ff, .cmdError_ff, .regionMode_ff,
  .lockIndicator_ff, .flashAddr, .dqOut, .dqOe, .ceN, .oeN, .weN,
  .resetN_ff
);
`default_nettype wire

// ---- secure_flash_model.sv ----
// Purpose: behavioural flash with a secure region
// Assumes: word mode, writes taken on weN release
// Notes:   array data reads as inverted address
`timescale 1ns/1ns
`default_nettype none
module secure_flash_model
#(parameter LOCKED = 0)
(
  input wire logic        core_clk,
  input wire logic        rstDevN,
  input wire logic [23:0] flashAddr,
  input wire logic [15:0] dqOut,
  input wire logic        ceN,
  input wire logic        oeN,
  input wire logic        weN,
  output logic     [15:0] dqIn
);
  logic [15:0] mem [0:127];
  logic [15:0] wd, rd, hold;
  logic [23:0] wa;
  logic [1:0]  st;
  logic        wasLow, mode, idm, prog;
  initial
    for (int i = 0; i < 128; i++)
      mem[i] = (i < 8) ? 16'h5E00 + i : 16'hFFFF;
  // no accel or bypass path exists
  assign rd = idm ? (flashAddr[7:0] == 8'h03 ? {8'h00, LOCKED[0], 7'h00}
    : 16'h0000) : (mode && flashAddr <= 24'h00FFFF) ? (flashAddr < 128
    ? mem[flashAddr[6:0]] : 16'hDEAD) : ~flashAddr[15:0];
  assign dqIn = (!ceN && !oeN && rstDevN) ? rd : ~hold;
  always @(posedge core_clk)
    if (!ceN && !oeN)
      hold <= rd;
  always @(posedge core_clk or negedge rstDevN)
    if (!rstDevN)
    begin
      st <= 0;
      mode <= 0;
      idm <= 0;
      prog <= 0;
      wasLow <= 0;
    end
    else
    begin
      wasLow <= !weN && !ceN;
      if (!weN)
      begin
        wa <= flashAddr;
        wd <= dqOut;
      end
      if (wasLow && weN)
      begin
        st <= 0;
        if (prog)
        begin
          prog <= 0;
          if (mode && wa < 128 && !LOCKED)
            mem[wa[6:0]] <= wd;
        end
        else if (st == 3)
          mode <= mode && wd != 16'h0000;
        else if (wd == 16'h00F0)
          idm <= 0;
        else if (st == 0 && wa == 24'h000555 && wd == 16'h00AA)
          st <= 1;
        else if (st == 1 && wa == 24'h0002AA && wd == 16'h0055)
          st <= 2;
        else if (st == 2 && wa == 24'h000555)
          case (wd)
            16'h0088: mode <= 1;
            16'h00A0: prog <= 1;
            16'h0090: if (mode) st <= 3; else idm <= 1;
            default: st <= 0;
          endcase
      end
    end
endmodule // secure_flash_model
`default_nettype wire

// ---- secure_region_host_tb.sv ----
// Purpose: self-checking bench for the secure region host
// Assumes: unlocked and factory-locked flash models
// Notes:   random program data from an lfsr
`timescale 1ns/1ns
`default_nettype none
`include "secure_region_consts.vh"
module secure_region_host_tb;
  logic        core_clk = 0, rstn = 0, cmdValid = 0;
  logic [2:0]  cmdCode = 0;
  logic [23:0] cmdAddr = 0, flashAddr, a;
  logic [15:0] cmdData = 0, dqIn, dqOut, rspData_ff, d;
  logic        cmdBusy_ff, cmdDone_ff, cmdError_ff, regionMode_ff;
  logic        lockIndicator_ff, dqOe, ceN, oeN, weN, resetN_ff;
  logic [23:0] fa2;
  logic [15:0] dqIn2, dq2, rsp2;
  logic        busy2, done2, err2, mode2, lock2, ce2, oe2, we2, rst2;
  logic [31:0] rnd = 32'hDA3D;
  int          bad_count = 0, tests_run = 0, cyc = 0;
  always #4 core_clk = ~core_clk;
  secure_region_host u_secure_region_host (.core_clk, .rstn, .cmdValid,
    .cmdCode, .cmdAddr, .cmdData, .dqIn, .cmdBusy_ff, .cmdDone_ff,
    .cmdError_ff, .rspData_ff, .regionMode_ff, .lockIndicator_ff,
    .flashAddr, .dqOut, .dqOe, .ceN, .oeN, .weN, .resetN_ff);
  secure_flash_model #(.LOCKED(0)) u_secure_flash_model (.core_clk,
    .rstDevN(resetN_ff), .flashAddr, .dqOut, .ceN, .oeN, .weN, .dqIn);
  // second pair with a factory-locked part, same orders in lock step
  secure_region_host u_secure_region_host_locked (.core_clk, .rstn,
    .cmdValid, .cmdCode, .cmdAddr, .cmdData, .dqIn(dqIn2),
    .cmdBusy_ff(busy2), .cmdDone_ff(done2), .cmdError_ff(err2),
    .rspData_ff(rsp2), .regionMode_ff(mode2), .lockIndicator_ff(lock2),
    .flashAddr(fa2), .dqOut(dq2), .dqOe(), .ceN(ce2), .oeN(oe2),
    .weN(we2), .resetN_ff(rst2));
  secure_flash_model #(.LOCKED(1)) u_secure_flash_model_locked
    (.core_clk, .rstDevN(rst2), .flashAddr(fa2), .dqOut(dq2), .ceN(ce2),
    .oeN(oe2), .weN(we2), .dqIn(dqIn2));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] arrayWord(logic [23:0] ad);
    return ~ad[15:0];
  endfunction
  task automatic results();
    $display("tests %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic order(logic [2:0] c, logic [23:0] ad, logic [15:0] dt,
                       logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    cmdValid <= 1;
    cmdCode <= c;
    cmdAddr <= ad;
    cmdData <= dt;
    @(posedge core_clk);
    cmdValid <= 0;
    @(posedge core_clk);
    chk("busy", cmdBusy_ff, !err);
    while (cmdDone_ff !== 1'b1 && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000)
      bad_count++;
    chk("error", cmdError_ff, err);
  endtask
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      results();
    end
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    rstn <= 1;
    repeat (2) @(posedge core_clk);
    order(5, 0, 0, 0);
    chk("lockbit", lockIndicator_ff, 0);
    chk("lockbit2", lock2, 1);
    order(4, 24'h000010, 0, 0);
    chk("array", rspData_ff, arrayWord(24'h000010));
    order(2, 8, 1, 1);
    order(3, 0, 0, 1);
    order(7, 0, 0, 1);
    $display("test idle done");
    order(1, 0, 0, 0);
    chk("mode", regionMode_ff, 1);
    order(1, 0, 0, 1);
    for (int i = 0; i < 8; i++)
    begin
      order(4, i, 0, 0);
      chk("serial", rspData_ff, 16'h5E00 + i);
    end
    $display("test enter done");
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      a = 8 + rnd[6:0] % 120;
      d = rnd[31:16] | 16'h0180;
      order(2, a, d, 0);
      order(4, a, 0, 0);
      chk("program", rspData_ff, d);
      chk("locked", rsp2, 16'hFFFF);
    end
    order(4, 24'h010020, 0, 0);
    chk("outside", rspData_ff, arrayWord(24'h010020));
    order(4, 24'h000080, 0, 1);
    order(5, 0, 0, 1);
    chk("mode", regionMode_ff, 1);
    $display("test program done");
    order(3, 0, 0, 0);
    chk("mode", regionMode_ff, 0);
    order(4, 24'h000008, 0, 0);
    chk("array", rspData_ff, arrayWord(24'h000008));
    $display("test exit done");
    order(1, 0, 0, 0);
    order(6, 0, 0, 0);
    chk("mode", regionMode_ff, 0);
    order(4, 0, 0, 0);
    chk("array", rspData_ff, arrayWord(24'h000000));
    $display("test reset done");
    results();
  end
endmodule // secure_region_host_tb
`default_nettype wire
